// ### hw/surface_descriptor_decode.sv
// surface descriptor latch and field decoder for the engine units
// assumes descriptor words are delivered by the fetch logic on the same clock
module surface_descriptor_decode
	import surf_desc_pkg::*;
(
	// clock, reset and enable
	input wire logic sys_clk,
	input wire logic rst,
	input wire logic ce,
	// fetched descriptor
	input wire logic desc_load,
	input wire logic [2:0] desc_kind,
	input wire logic desc_media,
	input wire logic [31:0] desc_dw0,
	input wire logic [31:0] desc_dw1,
	input wire logic [31:0] desc_dw2,
	input wire logic [31:0] desc_dw3,
	input wire logic [31:0] org_dx_bytes,
	input wire logic [31:0] org_dy_bytes,
	// media block read row request
	input wire logic mrow_req,
	input wire logic signed [15:0] mrow_row,
	// decoded descriptor
	output logic desc_ready,
	output logic [2:0] kind_out,
	output logic mip_level1_sideways,
	output logic rc_alloc_read_write,
	output logic [5:0] face_border,
	output logic [31:0] base_addr,
	output logic [31:0] origin_addr,
	output logic [12:0] width_m1,
	output logic [12:0] height_m1,
	output logic [10:0] depth_m1,
	output logic [26:0] buf_entries_m1,
	output logic height_is_field,
	output logic width_in_dwords,
	output logic [3:0] mip_levels,
	output logic [3:0] rt_lod,
	// media row answer
	output logic mrow_valid,
	output logic [14:0] mrow_phys
);
	////////////////////////////////////////////////////////////////////////////////
	// latch stage
	desc_state_e state_reg, state_next;
	logic [31:0] dw0_reg, dw0_next;
	logic [31:0] dw1_reg, dw1_next;
	logic [31:0] dw2_reg, dw2_next;
	logic [31:0] dw3_reg, dw3_next;
	logic [31:0] dx_reg, dx_next;
	logic [31:0] dy_reg, dy_next;
	logic [2:0] kind_reg, kind_next;
	logic media_reg, media_next;
	// capture a descriptor, then decode it once before any use
	always_comb begin
		state_next = state_reg;
		dw0_next = dw0_reg;
		dw1_next = dw1_reg;
		dw2_next = dw2_reg;
		dw3_next = dw3_reg;
		dx_next = dx_reg;
		dy_next = dy_reg;
		kind_next = kind_reg;
		media_next = media_reg;
		if (desc_load) begin
			state_next = ST_DECODE;
			dw0_next = desc_dw0;
			dw1_next = desc_dw1;
			dw2_next = desc_dw2;
			dw3_next = desc_dw3;
			dx_next = org_dx_bytes;
			dy_next = org_dy_bytes;
			kind_next = desc_kind;
			media_next = desc_media;
		end else begin
			case (state_reg)
				ST_EMPTY: state_next = ST_EMPTY;
				ST_DECODE: state_next = ST_READY;
				ST_READY: state_next = ST_READY;
				default: state_next = ST_EMPTY;
			endcase
		end
	end
	// register the latch stage
	always_ff @(posedge sys_clk) begin
		if (rst) begin
			state_reg <= ST_EMPTY;
			dw0_reg <= DW_RESET;
			dw1_reg <= DW_RESET;
			dw2_reg <= DW_RESET;
			dw3_reg <= DW_RESET;
			dx_reg <= DW_RESET;
			dy_reg <= DW_RESET;
			kind_reg <= one_dim_surface_kind;
			media_reg <= 1'h0;
		end else if (ce) begin
			state_reg <= state_next;
			dw0_reg <= dw0_next;
			dw1_reg <= dw1_next;
			dw2_reg <= dw2_next;
			dw3_reg <= dw3_next;
			dx_reg <= dx_next;
			dy_reg <= dy_next;
			kind_reg <= kind_next;
			media_reg <= media_next;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// fields of the latched descriptor
	logic f_vstride, f_vofs, f_layout, f_rc, f_tiled;
	logic [1:0] f_bnd;
	logic [5:0] f_cube;
	logic [12:0] f_height, f_width;
	logic [3:0] f_mip;
	logic [10:0] f_depth;
	logic is_cube, is_flat, is_buffer;
	logic [5:0] face_off;
	// slice the words
	assign f_vstride = dw0_reg[VSTRIDE_BIT];
	assign f_vofs = dw0_reg[VSTRIDE_OFS_BIT];
	assign f_layout = dw0_reg[LAYOUT_BIT];
	assign f_rc = dw0_reg[RC_MODE_BIT];
	assign f_bnd = dw0_reg[BND_HI:BND_LO];
	assign f_cube = dw0_reg[CUBE_HI:CUBE_LO];
	assign f_height = dw2_reg[HEIGHT_HI:HEIGHT_LO];
	assign f_width = dw2_reg[WIDTH_HI:WIDTH_LO];
	assign f_mip = dw2_reg[MIP_HI:MIP_LO];
	assign f_depth = dw3_reg[DEPTH_HI:DEPTH_LO];
	assign f_tiled = dw3_reg[TILED_BIT];
	// surface kind tests
	assign is_cube = (kind_reg == six_face_surface_kind);
	assign is_flat = (kind_reg == one_dim_surface_kind) || (kind_reg == two_dim_surface_kind);
	assign is_buffer = (kind_reg == linear_array_surface_kind);
	// one border flag per face, only cube surfaces look at the mask
	for (genvar i = 0; i < CUBE_FACES; i++) begin : g_face
		assign face_off[i] = is_cube & ~f_cube[i];
	end

	////////////////////////////////////////////////////////////////////////////////
	// decode stage
	logic [2:0] kind_out_reg, kind_out_next;
	logic sideways_reg, sideways_next;
	logic rc_rw_reg, rc_rw_next;
	logic [5:0] face_reg, face_next;
	logic [31:0] base_reg, base_next;
	logic [31:0] origin_reg, origin_next;
	logic [12:0] width_reg, width_next;
	logic [12:0] height_reg, height_next;
	logic [10:0] depth_reg, depth_next;
	logic [26:0] bufn_reg, bufn_next;
	logic hfield_reg, hfield_next;
	logic wdw_reg, wdw_next;
	logic [3:0] levels_reg, levels_next;
	logic [3:0] lod_reg, lod_next;
	// recompute the outputs while a fresh descriptor is decoded
	always_comb begin
		kind_out_next = kind_out_reg;
		sideways_next = sideways_reg;
		rc_rw_next = rc_rw_reg;
		face_next = face_reg;
		base_next = base_reg;
		origin_next = origin_reg;
		width_next = width_reg;
		height_next = height_reg;
		depth_next = depth_reg;
		bufn_next = bufn_reg;
		hfield_next = hfield_reg;
		wdw_next = wdw_reg;
		levels_next = levels_reg;
		lod_next = lod_reg;
		if (state_reg == ST_DECODE) begin
			kind_out_next = kind_reg;
			sideways_next = is_flat && (f_layout == mip_stack_sideways);
			rc_rw_next = f_rc;
			face_next = face_off;
			base_next = dw1_reg;
			origin_next = f_tiled ? dw1_reg + dx_reg + dy_reg : dw1_reg;
			width_next = f_width;
			height_next = f_height;
			depth_next = f_depth;
			bufn_next = is_buffer ? {f_depth[BUF_D_BITS-1:0], f_height, f_width[BUF_W_BITS-1:0]} : 27'h0;
			hfield_next = f_vstride;
			wdw_next = media_reg;
			levels_next = f_mip + LOD_ONE;
			lod_next = f_mip;
		end
	end
	// register the decode stage
	always_ff @(posedge sys_clk) begin
		if (rst) begin
			kind_out_reg <= one_dim_surface_kind;
			sideways_reg <= mip_stack_downward;
			rc_rw_reg <= 1'h0;
			face_reg <= 6'h00;
			base_reg <= DW_RESET;
			origin_reg <= DW_RESET;
			width_reg <= 13'h0000;
			height_reg <= 13'h0000;
			depth_reg <= 11'h000;
			bufn_reg <= 27'h0;
			hfield_reg <= 1'h0;
			wdw_reg <= 1'h0;
			levels_reg <= LOD_ONE;
			lod_reg <= 4'h0;
		end else if (ce) begin
			kind_out_reg <= kind_out_next;
			sideways_reg <= sideways_next;
			rc_rw_reg <= rc_rw_next;
			face_reg <= face_next;
			base_reg <= base_next;
			origin_reg <= origin_next;
			width_reg <= width_next;
			height_reg <= height_next;
			depth_reg <= depth_next;
			bufn_reg <= bufn_next;
			hfield_reg <= hfield_next;
			wdw_reg <= wdw_next;
			levels_reg <= levels_next;
			lod_reg <= lod_next;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// media row stage
	logic [14:0] clamp_row;
	logic take_row;
	logic mrow_valid_reg, mrow_valid_next;
	logic [14:0] mrow_phys_reg, mrow_phys_next;
	// boundary handling of one requested row
	media_row_clamp u_clamp (.mode(f_bnd), .field_mode(f_vstride), .field_odd(f_vofs), .height_m1(f_height),
		.row_req(mrow_row), .row_phys(clamp_row));
	// rows are served only from a decoded descriptor
	assign take_row = mrow_req && (state_reg == ST_READY);
	// answer one cycle after a taken request
	always_comb begin
		mrow_valid_next = take_row;
		mrow_phys_next = take_row ? clamp_row : mrow_phys_reg;
	end
	// register the row answer
	always_ff @(posedge sys_clk) begin
		if (rst) begin
			mrow_valid_reg <= 1'h0;
			mrow_phys_reg <= ROW_RESET;
		end else if (ce) begin
			mrow_valid_reg <= mrow_valid_next;
			mrow_phys_reg <= mrow_phys_next;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// outputs
	assign desc_ready = (state_reg == ST_READY);
	assign kind_out = kind_out_reg;
	assign mip_level1_sideways = sideways_reg;
	assign rc_alloc_read_write = rc_rw_reg;
	assign face_border = face_reg;
	assign base_addr = base_reg;
	assign origin_addr = origin_reg;
	assign width_m1 = width_reg;
	assign height_m1 = height_reg;
	assign depth_m1 = depth_reg;
	assign buf_entries_m1 = bufn_reg;
	assign height_is_field = hfield_reg;
	assign width_in_dwords = wdw_reg;
	assign mip_levels = levels_reg;
	assign rt_lod = lod_reg;
	assign mrow_valid = mrow_valid_reg;
	assign mrow_phys = mrow_phys_reg;

	////////////////////////////////////////////////////////////////////////////////
	// checks
	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (rst);

	sequence s_row_taken;
		mrow_req && ce && desc_ready;
	endsequence
	sequence s_load_then_run;
		(desc_load && ce) ##1 (ce && !desc_load);
	endsequence
	AST_READY_AFTER_LOAD: assert property (s_load_then_run |=> desc_ready)
		else $error("descriptor not ready two enabled cycles after load");
	AST_NO_ROW_UNLATCHED: assert property (mrow_req && ce && !desc_ready |=> !mrow_valid)
		else $error("row answered without a decoded descriptor");
	AST_LAYOUT: assert property (desc_ready |-> mip_level1_sideways == (is_flat && f_layout))
		else $error("mip layout does not follow latched bit");
	AST_RC_ALLOC: assert property (desc_ready |-> rc_alloc_read_write == f_rc)
		else $error("render cache allocation mode wrong");
	AST_FACE_MASK: assert property (desc_ready && is_cube |-> face_border == ~f_cube)
		else $error("cube face border flags do not match mask");
	AST_FACE_IGNORED: assert property (desc_ready && !is_cube |-> face_border == 6'h00)
		else $error("face mask used on non-cube surface");
	AST_BUF_SPLIT: assert property (desc_ready && is_buffer |->
		buf_entries_m1 == {f_depth[6:0], f_height, f_width[6:0]})
		else $error("buffer entry count misassembled");
	AST_MIP_COUNT: assert property (desc_ready |-> mip_levels == f_mip + 4'h1 && rt_lod == f_mip)
		else $error("mip level count or lod wrong");
	AST_ORIGIN: assert property (desc_ready && f_tiled |-> origin_addr == base_addr + dx_reg + dy_reg)
		else $error("tiled origin not displaced by offsets");
	AST_ROW_WHOLE_FRAME: assert property (s_row_taken ##0 (f_vstride && f_bnd == 2'h2 && mrow_row < 0)
		|=> mrow_valid && mrow_phys == 15'h0000)
		else $error("whole frame clamp below top wrong");
	AST_ROW_FIELD: assert property (s_row_taken ##0 (f_vstride && f_bnd == 2'h0 && mrow_row > $signed({3'h0, f_height}))
		|=> mrow_phys == {1'h0, $past(f_height), 1'h0} + {14'h0000, $past(f_vofs)})
		else $error("field clamp left the field");
	AST_ROW_PARITY: assert property (s_row_taken ##0 (!f_vstride && f_bnd == 2'h3 && mrow_row < 0)
		|=> mrow_phys == {14'h0000, $past(mrow_row[0])})
		else $error("parity preserving clamp wrong");

endmodule : surface_descriptor_decode

// ### hw/surf_desc_pkg.sv
// constants shared by the surface descriptor decoder and its row clamp
// assumes descriptor words arrive already fetched from memory, one word per port
package surf_desc_pkg;

	////////////////////////////////////////////////////////////////////////////////
	// descriptor word 0 field positions
	localparam int VSTRIDE_BIT = 12;
	localparam int VSTRIDE_OFS_BIT = 11;
	localparam int LAYOUT_BIT = 10;
	localparam int RC_MODE_BIT = 8;
	localparam int BND_HI = 7;
	localparam int BND_LO = 6;
	localparam int CUBE_HI = 5;
	localparam int CUBE_LO = 0;
	localparam int CUBE_FACES = 6;

	// descriptor word 2 field positions
	localparam int HEIGHT_HI = 31;
	localparam int HEIGHT_LO = 19;
	localparam int WIDTH_HI = 18;
	localparam int WIDTH_LO = 6;
	localparam int MIP_HI = 5;
	localparam int MIP_LO = 2;

	// descriptor word 3 field positions
	localparam int DEPTH_HI = 31;
	localparam int DEPTH_LO = 21;
	localparam int TILED_BIT = 1;

	// buffer entry count split: low, middle and high slices
	localparam int BUF_W_BITS = 7;
	localparam int BUF_D_BITS = 7;

	////////////////////////////////////////////////////////////////////////////////
	// reset values
	localparam logic [31:0] DW_RESET = 32'h0000_0000;
	localparam logic [14:0] ROW_RESET = 15'h0000;

	// surface kinds
	localparam logic [2:0] one_dim_surface_kind = 3'h0;
	localparam logic [2:0] two_dim_surface_kind = 3'h1;
	localparam logic [2:0] volume_surface_kind = 3'h2;
	localparam logic [2:0] six_face_surface_kind = 3'h3;
	localparam logic [2:0] linear_array_surface_kind = 3'h4;

	// mip layout codes
	localparam logic mip_stack_downward = 1'h0;
	localparam logic mip_stack_sideways = 1'h1;

	// media boundary codes
	localparam logic [1:0] boundary_nearest_rows = 2'h0;
	localparam logic [1:0] boundary_reserved = 2'h1;
	localparam logic [1:0] boundary_whole_picture_rows = 2'h2;
	localparam logic [1:0] boundary_parity_preserving_rows = 2'h3;

	// mip count code to level count
	localparam logic [3:0] LOD_ONE = 4'h1;

	// descriptor life cycle
	typedef enum logic [1:0] {ST_EMPTY, ST_DECODE, ST_READY} desc_state_e;

endpackage : surf_desc_pkg

// ### hw/media_row_clamp.sv
// out-of-bounds row selection for media block reads
// assumes height and field setup come from an already latched descriptor
module media_row_clamp
	import surf_desc_pkg::*;
(
	// boundary mode and field setup
	input wire logic [1:0] mode,
	input wire logic field_mode,
	input wire logic field_odd,
	input wire logic [12:0] height_m1,
	// requested row in frame or field units, may be out of bounds
	input wire logic signed [15:0] row_req,
	// physical row of the surface to return
	output logic [14:0] row_phys
);

	////////////////////////////////////////////////////////////////////////////////
	// clamp the row according to the boundary mode
	always_comb begin
		logic signed [17:0] hi;
		logic signed [17:0] r;
		logic signed [17:0] p;
		logic signed [17:0] pmax;
		logic signed [17:0] odd;
		logic signed [17:0] sel;
		hi = $signed({5'h00, height_m1});
		r = {{2{row_req[15]}}, row_req};
		odd = $signed({17'h00000, field_odd});
		p = (r <<< 1) + odd;
		pmax = (hi <<< 1) + 18'sh00001;
		sel = r;
		if (field_mode && mode == boundary_whole_picture_rows) begin
			// whole frame rows, the other field may be returned
			if (p < 18'sh00000)
				sel = 18'sh00000;
			else if (p > pmax)
				sel = pmax;
			else
				sel = p;
		end else if (!field_mode && mode == boundary_parity_preserving_rows) begin
			// frame mode keeps even or odd parity of the row
			if (r < 18'sh00000)
				sel = $signed({17'h00000, r[0]});
			else if (r > hi)
				sel = (r[0] == hi[0] || hi == 18'sh00000) ? hi : hi - 18'sh00001;
			else
				sel = r;
		end else begin
			// nearest row of the current frame or field, reserved code alike
			if (r < 18'sh00000)
				sel = 18'sh00000;
			else if (r > hi)
				sel = hi;
			else
				sel = r;
			// field rows map to one parity only
			if (field_mode)
				sel = (sel <<< 1) + odd;
		end
		row_phys = sel[14:0];
	end

endmodule : media_row_clamp

// ### bench/desc_writer.sv
// software side model: packs surface fields into the four descriptor words
// assumes the bench sets the fields and reads the words back combinationally
module desc_writer
	import surf_desc_pkg::*;
(
	// surface fields
	input wire logic [2:0] kind,
	input wire logic layout,
	input wire logic rc_mode,
	input wire logic [1:0] bnd,
	input wire logic vstride,
	input wire logic vofs,
	input wire logic [5:0] faces,
	input wire logic [31:0] base,
	input wire logic tiled,
	input wire logic [12:0] width,
	input wire logic [12:0] height,
	input wire logic [10:0] depth,
	input wire logic [3:0] mip,
	input wire logic [26:0] count_m1,
	// descriptor words
	output logic [31:0] dw0,
	output logic [31:0] dw1,
	output logic [31:0] dw2,
	output logic [31:0] dw3
);
	logic is_buf;
	logic [12:0] h_field;
	logic [10:0] d_field;
	logic [12:0] w_field;
	// pitch of every surface the model builds, in bytes minus one
	localparam logic [12:0] PITCH_M1 = 13'h0fff;

	////////////////////////////////////////////////////////////////////////////////
	// field selection by surface kind
	assign is_buf = (kind == linear_array_surface_kind);
	assign h_field = (kind == one_dim_surface_kind) ? 13'h0000 : height;
	assign d_field = (kind == six_face_surface_kind) ? 11'h000 : depth;
	assign w_field = (width > PITCH_M1) ? PITCH_M1 : width;

	// word 0: sideways layout only for 2D surfaces
	always_comb begin
		dw0 = 32'h0000_0000;
		dw0[VSTRIDE_BIT] = vstride;
		dw0[VSTRIDE_OFS_BIT] = vofs;
		dw0[LAYOUT_BIT] = layout & (kind == two_dim_surface_kind);
		dw0[RC_MODE_BIT] = rc_mode;
		dw0[BND_HI:BND_LO] = bnd;
		dw0[CUBE_HI:CUBE_LO] = faces;
	end

	// word 1: tiled bases land on a 4KB boundary
	assign dw1 = tiled ? {base[31:12], 12'h000} : base;

	// word 2: dimensions, or the low and middle buffer count slices
	always_comb begin
		dw2 = 32'h0000_0000;
		dw2[HEIGHT_HI:HEIGHT_LO] = is_buf ? count_m1[19:7] : h_field;
		dw2[WIDTH_HI:WIDTH_LO] = is_buf ? {6'h00, count_m1[6:0]} : w_field;
		dw2[MIP_HI:MIP_LO] = mip;
	end

	// word 3: depth or high count slice; buffers are never tiled
	always_comb begin
		dw3 = 32'h0000_0000;
		dw3[DEPTH_HI:DEPTH_LO] = is_buf ? {4'h0, count_m1[26:20]} : d_field;
		dw3[TILED_BIT] = tiled & ~is_buf;
	end
endmodule : desc_writer

// ### bench/surface_descriptor_decode_bench.sv
// self-checking bench for the surface descriptor decoder
// assumes the software model packs descriptors from the fields set here
module surface_descriptor_decode_bench
	import surf_desc_pkg::*;
;
	timeunit 1ns;
	timeprecision 100ps;

	logic sys_clk = 1'b0, rst = 1'b1, ce = 1'b1, desc_load = 1'b0, desc_media = 1'b0, mrow_req = 1'b0;
	logic [2:0] kind = 3'h0;
	logic layout = 1'b0, rc_mode = 1'b0, vstride = 1'b0, vofs = 1'b0, tiled = 1'b0;
	logic [1:0] bnd = 2'h0;
	logic [5:0] faces = 6'h00;
	logic [31:0] base = 32'h0, dx = 32'h0, dy = 32'h0, dw0, dw1, dw2, dw3;
	logic [12:0] width = 13'h0, height = 13'h0, width_m1, height_m1;
	logic [10:0] depth = 11'h0, depth_m1;
	logic [3:0] mip = 4'h0, mip_levels, rt_lod;
	logic [26:0] count_m1 = 27'h0, buf_entries_m1;
	logic signed [15:0] mrow_row = 16'sh0;
	logic desc_ready, mip_level1_sideways, rc_alloc_read_write, height_is_field, width_in_dwords, mrow_valid;
	logic [2:0] kind_out;
	logic [5:0] face_border;
	logic [31:0] base_addr, origin_addr;
	logic [14:0] mrow_phys;
	int failures = 0, num_checks = 0, cycles = 0;

	////////////////////////////////////////////////////////////////////////////////
	// clock, software model and design
	always #12.5 sys_clk = ~sys_clk;

	desc_writer desc_writer_i (.kind(kind), .layout(layout), .rc_mode(rc_mode), .bnd(bnd), .vstride(vstride),
		.vofs(vofs), .faces(faces), .base(base), .tiled(tiled), .width(width), .height(height), .depth(depth),
		.mip(mip), .count_m1(count_m1), .dw0(dw0), .dw1(dw1), .dw2(dw2), .dw3(dw3));

	surface_descriptor_decode surface_descriptor_decode_i (.sys_clk(sys_clk), .rst(rst), .ce(ce),
		.desc_load(desc_load), .desc_kind(kind), .desc_media(desc_media), .desc_dw0(dw0), .desc_dw1(dw1),
		.desc_dw2(dw2), .desc_dw3(dw3), .org_dx_bytes(dx), .org_dy_bytes(dy), .mrow_req(mrow_req),
		.mrow_row(mrow_row), .desc_ready(desc_ready), .kind_out(kind_out), .mip_level1_sideways(mip_level1_sideways),
		.rc_alloc_read_write(rc_alloc_read_write), .face_border(face_border), .base_addr(base_addr),
		.origin_addr(origin_addr), .width_m1(width_m1), .height_m1(height_m1), .depth_m1(depth_m1),
		.buf_entries_m1(buf_entries_m1), .height_is_field(height_is_field), .width_in_dwords(width_in_dwords),
		.mip_levels(mip_levels), .rt_lod(rt_lod), .mrow_valid(mrow_valid), .mrow_phys(mrow_phys));

	////////////////////////////////////////////////////////////////////////////////
	// comparison, verdict and hang guard
	task automatic check(input logic [31:0] got, input logic [31:0] exp, input string what);
		num_checks++;
		if (got !== exp) begin
			failures++;
			$display("MISMATCH t=%0t %s got %h exp %h", $time, what, got, exp);
		end
	endtask : check

	task automatic stop_test;
		$display("checks %0d mismatches %0d", num_checks, failures);
		if (failures == 0 && num_checks > 0) begin
			$display("Finished cleanly");
		end else begin
			$display("Finished with errors");
		end
		$finish;
	endtask : stop_test

	always @(posedge sys_clk) begin
		cycles++;
		if (cycles == 5000) begin
			failures++;
			stop_test();
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// shared bus steps
	task automatic load_desc;
		@(posedge sys_clk);
		desc_load <= 1'b1;
		@(posedge sys_clk);
		desc_load <= 1'b0;
		#1 check(desc_ready, 0, "ready during decode");
		@(posedge sys_clk);
		#1 check(desc_ready, 1, "ready after decode");
	endtask : load_desc

	task automatic row(input logic signed [15:0] r, input logic [14:0] exp);
		@(posedge sys_clk);
		mrow_req <= 1'b1;
		mrow_row <= r;
		@(posedge sys_clk);
		mrow_req <= 1'b0;
		#1 check(mrow_valid, 1, "row valid");
		check(mrow_phys, exp, "row phys");
		@(posedge sys_clk);
		#1 check(mrow_valid, 0, "row pulse end");
	endtask : row

	task automatic rows_setup(input logic [1:0] m, input logic vs);
		@(posedge sys_clk);
		kind <= two_dim_surface_kind;
		height <= 13'h0009;
		bnd <= m;
		vstride <= vs;
		vofs <= vs;
		load_desc();
	endtask : rows_setup

	////////////////////////////////////////////////////////////////////////////////
	// scenarios
	task automatic t_reset;
		#1 check(desc_ready, 0, "reset ready");
		check(mip_levels, 4'h1, "reset mip levels");
		check(base_addr, 0, "reset base");
		@(posedge sys_clk);
		mrow_req <= 1'b1;
		@(posedge sys_clk);
		mrow_req <= 1'b0;
		#1 check(mrow_valid, 0, "refused row");
		$display("test reset done");
	endtask : t_reset

	task automatic t_two_dim;
		@(posedge sys_clk);
		kind <= two_dim_surface_kind;
		{layout, rc_mode, vstride, desc_media} <= 4'hf;
		faces <= 6'h15;
		{width, height, depth, mip} <= {13'h1f3, 13'h00ff, 11'h1ff, 4'hd};
		{base, dx} <= {32'h0000_0003, 32'h0000_0040};
		load_desc();
		check(mip_level1_sideways, mip_stack_sideways, "layout");
		check(rc_alloc_read_write, 1, "rc mode");
		check(face_border, 0, "faces ignored");
		check(width_m1, 13'h1f3, "width");
		check(height_m1, 13'h00ff, "height");
		check(depth_m1, 11'h1ff, "depth");
		check(mip_levels, 4'he, "mip levels");
		check(rt_lod, 4'hd, "render lod");
		check(height_is_field, 1, "field height");
		check(width_in_dwords, 1, "dword width");
		check(origin_addr, 32'h0000_0003, "linear origin");
		check(buf_entries_m1, 0, "no buffer count");
		check(kind_out, two_dim_surface_kind, "kind out");
		$display("test two_dim done");
	endtask : t_two_dim

	task automatic t_cube;
		@(posedge sys_clk);
		kind <= six_face_surface_kind;
		{layout, rc_mode, vstride, desc_media, tiled} <= 5'h01;
		faces <= 6'h29;
		mip <= 4'h0;
		{base, dx, dy} <= {32'h1234_5678, 32'h0000_0040, 32'h0000_2000};
		load_desc();
		check(mip_level1_sideways, mip_stack_downward, "layout below");
		check(rc_alloc_read_write, 0, "rc write only");
		check(face_border, 6'h16, "face border");
		check(base_addr, 32'h1234_5000, "base");
		check(origin_addr, 32'h1234_7040, "tiled origin");
		check(depth_m1, 0, "cube depth");
		check(height_is_field, 0, "frame height");
		check(width_in_dwords, 0, "pixel width");
		check(mip_levels, 4'h1, "one level");
		$display("test cube done");
	endtask : t_cube

	task automatic t_buffer;
		@(posedge sys_clk);
		kind <= linear_array_surface_kind;
		tiled <= 1'b0;
		count_m1 <= 27'h4d2_c3b1;
		load_desc();
		check(buf_entries_m1, 27'h4d2_c3b1, "buffer count");
		check(width_m1, 13'h0031, "count low slice");
		check(face_border, 0, "buffer faces");
		$display("test buffer done");
	endtask : t_buffer

	task automatic t_rows;
		rows_setup(boundary_nearest_rows, 1'b0);
		row(-16'sd3, 15'h0000);
		row(16'sd20, 15'h0009);
		rows_setup(boundary_reserved, 1'b0);
		row(16'sd20, 15'h0009);
		rows_setup(boundary_parity_preserving_rows, 1'b0);
		row(-16'sd3, 15'h0001);
		row(16'sd20, 15'h0008);
		row(16'sd21, 15'h0009);
		rows_setup(boundary_whole_picture_rows, 1'b0);
		row(16'sd20, 15'h0009);
		rows_setup(boundary_nearest_rows, 1'b1);
		row(-16'sd2, 15'h0001);
		row(16'sd12, 15'h0013);
		rows_setup(boundary_whole_picture_rows, 1'b1);
		row(-16'sd2, 15'h0000);
		row(16'sd12, 15'h0013);
		rows_setup(boundary_parity_preserving_rows, 1'b1);
		row(-16'sd2, 15'h0001);
		$display("test rows done");
	endtask : t_rows

	task automatic t_freeze;
		@(posedge sys_clk);
		ce <= 1'b0;
		desc_load <= 1'b1;
		base <= 32'h0000_0abc;
		@(posedge sys_clk);
		desc_load <= 1'b0;
		mrow_req <= 1'b1;
		@(posedge sys_clk);
		mrow_req <= 1'b0;
		ce <= 1'b1;
		#1 check(desc_ready, 1, "load ignored while frozen");
		check(base_addr, 32'h1234_5678, "base held while frozen");
		check(mrow_valid, 0, "row ignored while frozen");
		load_desc();
		check(base_addr, 32'h0000_0abc, "base after thaw");
		@(posedge sys_clk);
		rst <= 1'b1;
		ce <= 1'b0;
		@(posedge sys_clk);
		rst <= 1'b0;
		ce <= 1'b1;
		#1 check(desc_ready, 0, "ready after mid-run reset");
		check(base_addr, 0, "base after mid-run reset");
		$display("test freeze done");
	endtask : t_freeze

	////////////////////////////////////////////////////////////////////////////////
	// main sequence
	initial begin
		repeat (3) @(posedge sys_clk);
		rst <= 1'b0;
		t_reset();
		t_two_dim();
		t_cube();
		t_buffer();
		t_rows();
		t_freeze();
		stop_test();
	end
endmodule : surface_descriptor_decode_bench
